/* logic/cpx_config_regs.sv */
// Purpose: Mode and orientation configuration bank of the crosspoint
// Assumes: Register port and status inputs are on clk_sys_i
// Notes:   Read data appears one clock after the read strobe
`timescale 1ns/1ps
module cpx_config_regs #(
    parameter logic [7:0] MISC_RESET  = 8'h00,
    parameter int         SYNC_STAGES = 2,
    parameter int         EQ_CODE_W   = 4
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      nrst_i,
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [7:0]                reg_rdata_o,
    input  wire logic [1:0]                hotplug_input_i,
    input  wire logic [EQ_CODE_W-1:0]      display_equalizer_pins_i,
    input  wire logic                      snoop_update_i,
    input  wire logic [1:0]                snoop_power_state_i,
    input  wire logic [4:0]                snoop_lane_count_i,
    input  wire logic [7:0]                usb_state_i,
    input  wire logic [7:0]                adaptive_equalization_result_i,
    output cpx_pkg::cpx_path_s             path_o,
    output logic      [3:0][EQ_CODE_W-1:0] lane_eq_o,
    output logic      [7:0]                tx_shaping_o,
    output logic [cpx_pkg::NUM_MISC-1:0][7:0] misc_o
);
    if (EQ_CODE_W != 4)
    begin : g_chk
        $error("EQ_CODE_W must be 4 to fill the lane EQ fields");
    end

    localparam int NM = cpx_pkg::NUM_MISC;

    typedef struct packed {
        cpx_pkg::cpx_mode_reg_s      mode;
        logic [7:0]                  tx_shape;
        logic [3:0][EQ_CODE_W-1:0]   eq_sw;
        cpx_pkg::cpx_snoop_s         snoop;
        logic [NM-1:0][7:0]          misc;
        logic [7:0]                  usb_stat;
        logic [7:0]                  aeq_res;
        logic [7:0]                  rdata;
        cpx_pkg::cpx_path_s          path;
        logic [3:0][EQ_CODE_W-1:0]   lane_eq;
    } cpx_state_s;

    cpx_state_s                st;
    cpx_state_s                next_st;
    logic [1:0]                hp_sync;
    logic [EQ_CODE_W-1:0]      eq_pins_sync;
    logic [3:0][EQ_CODE_W-1:0] lane_eff;
    logic                      hp_pin;
    logic                      upper_fall;

    // Pins are asynchronous to the register clock
    cpx_sync #(
        .W      (2),
        .STAGES (SYNC_STAGES)
    ) u_hp_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .d_i       (hotplug_input_i),
        .q_o       (hp_sync)
    );

    cpx_sync #(
        .W      (EQ_CODE_W),
        .STAGES (SYNC_STAGES)
    ) u_eq_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .d_i       (display_equalizer_pins_i),
        .q_o       (eq_pins_sync)
    );

    cpx_lane_eq #(
        .LANES  (4),
        .CODE_W (EQ_CODE_W)
    ) u_lane_eq (
        .src_sel_i (st.mode.equalizer_source_select),
        .sampled_i (eq_pins_sync),
        .sw_i      (st.eq_sw),
        .eff_o     (lane_eff)
    );

    always_comb
    begin
        next_st = st;
        hp_pin = 1'b0;
        upper_fall = 1'b0;

        // Status mirrors follow internal engines every clock
        next_st.usb_stat = usb_state_i;
        next_st.aeq_res  = adaptive_equalization_result_i;

        // Register writes
        if (reg_wr_i)
        begin
            if (reg_addr_i == cpx_pkg::OFS_MODE)
            begin
                // Reserved bit 6 masked off
                next_st.mode = cpx_pkg::cpx_mode_reg_s'(
                    reg_wdata_i & cpx_pkg::MASK_MODE);
            end
            else if (reg_addr_i == cpx_pkg::OFS_TXSHAPE)
            begin
                next_st.tx_shape =
                    reg_wdata_i & cpx_pkg::MASK_TXSHAPE;
            end
            else if (reg_addr_i == cpx_pkg::OFS_EQ01)
            begin
                // Writes only land while registers own the setting
                if (st.mode.equalizer_source_select)
                begin
                    next_st.eq_sw[1] = reg_wdata_i[7:4];
                    next_st.eq_sw[0] = reg_wdata_i[3:0];
                end
            end
            else if (reg_addr_i == cpx_pkg::OFS_EQ23)
            begin
                if (st.mode.equalizer_source_select)
                begin
                    next_st.eq_sw[3] = reg_wdata_i[7:4];
                    next_st.eq_sw[2] = reg_wdata_i[3:0];
                end
            end
            else
            begin
                // Read-only and unlisted offsets fall through here
                for (int i = 0; i < NM; i++)
                begin
                    if (reg_addr_i == cpx_pkg::MISC_OFS[i])
                        next_st.misc[i] = reg_wdata_i;
                end
            end
        end

        // Snoop status: clear on upper mode bit falling, update wins
        upper_fall = st.mode.operating_mode_select[1] &
                     ~next_st.mode.operating_mode_select[1];
        if (upper_fall)
            next_st.snoop = '0;
        if (snoop_update_i)
        begin
            next_st.snoop.power_state = snoop_power_state_i;
            next_st.snoop.lane_count  = snoop_lane_count_i;
        end

        // Datapath control from the current mode
        case (st.mode.operating_mode_select)
            cpx_pkg::MODE_OFF:
            begin
                next_st.path.usb_enable   = 1'b0;
                next_st.path.disp_lane_en = cpx_pkg::LANES_NONE;
            end
            cpx_pkg::MODE_USB:
            begin
                next_st.path.usb_enable   = 1'b1;
                next_st.path.disp_lane_en = cpx_pkg::LANES_NONE;
            end
            cpx_pkg::MODE_DISP4:
            begin
                next_st.path.usb_enable   = 1'b0;
                next_st.path.disp_lane_en = cpx_pkg::LANES_ALL;
            end
            default:
            begin
                next_st.path.usb_enable   = 1'b1;
                next_st.path.disp_lane_en = cpx_pkg::LANES_PAIR;
            end
        endcase
        next_st.path.flip = st.mode.flip;
        next_st.path.receive_pair_limiting_select =
            st.mode.receive_pair_limiting_select;

        // Hot-plug source and override
        hp_pin = st.mode.hotplug_pin_swap ? hp_sync[1] : hp_sync[0];
        next_st.path.hotplug_input_signal =
            st.mode.hotplug_force_high | hp_pin;

        // Lane EQ is registered so outputs come from flops
        next_st.lane_eq = lane_eff;

        // Read data holds until the next read strobe
        if (reg_rd_i)
        begin
            if (reg_addr_i == cpx_pkg::OFS_MODE)
                next_st.rdata = st.mode;
            else if (reg_addr_i == cpx_pkg::OFS_TXSHAPE)
                next_st.rdata = st.tx_shape;
            else if (reg_addr_i == cpx_pkg::OFS_EQ01)
                next_st.rdata = {lane_eff[1], lane_eff[0]};
            else if (reg_addr_i == cpx_pkg::OFS_EQ23)
                next_st.rdata = {lane_eff[3], lane_eff[2]};
            else if (reg_addr_i == cpx_pkg::OFS_SNOOP)
                next_st.rdata = st.snoop;
            else if (reg_addr_i == cpx_pkg::OFS_USB_STAT)
                next_st.rdata = st.usb_stat;
            else if (reg_addr_i == cpx_pkg::OFS_AEQ_RES)
                next_st.rdata = st.aeq_res;
            else
            begin
                next_st.rdata = cpx_pkg::RST_ZERO;
                for (int i = 0; i < NM; i++)
                begin
                    if (reg_addr_i == cpx_pkg::MISC_OFS[i])
                        next_st.rdata = st.misc[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            st                 <= '0;
            st.mode            <= cpx_pkg::cpx_mode_reg_s'(cpx_pkg::RST_MODE);
            st.tx_shape        <= cpx_pkg::RST_TXSHAPE;
            st.misc            <= {NM{MISC_RESET}};
            // Matches the reset mode so the path is sane at once
            st.path.usb_enable <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_o  = st.rdata;
    assign path_o       = st.path;
    assign lane_eq_o    = st.lane_eq;
    assign tx_shaping_o = st.tx_shape;
    assign misc_o       = st.misc;
endmodule

/* logic/cpx_lane_eq.sv */
// Purpose: Per-lane receive equalizer source selection
// Assumes: One sampled pin code is shared by every lane
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/1ps
module cpx_lane_eq #(
    parameter int LANES  = 4,
    parameter int CODE_W = 4
) (
    input  wire logic                         src_sel_i,
    input  wire logic [CODE_W-1:0]            sampled_i,
    input  wire logic [LANES-1:0][CODE_W-1:0] sw_i,
    output logic      [LANES-1:0][CODE_W-1:0] eff_o
);
    if (LANES < 1 || CODE_W < 1)
    begin : g_chk
        $error("cpx_lane_eq needs LANES >= 1 and CODE_W >= 1");
    end

    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        // Pins rule until software takes over
        assign eff_o[i] = src_sel_i ? sw_i[i] : sampled_i;
    end
endmodule

/* logic/cpx_pkg.sv */
// Purpose: Shared constants and types for the crosspoint config bank
// Assumes: Byte-wide registers on a byte register port
// Notes:   Offsets are the byte offsets of the register port
package cpx_pkg;

    localparam logic [7:0] OFS_MODE     = 8'h0A;
    localparam logic [7:0] OFS_TXSHAPE  = 8'h0B;
    localparam logic [7:0] OFS_EQ01     = 8'h10;
    localparam logic [7:0] OFS_EQ23     = 8'h11;
    localparam logic [7:0] OFS_SNOOP    = 8'h12;
    localparam logic [7:0] OFS_LANE_EN  = 8'h13;
    localparam logic [7:0] OFS_AEQ_A    = 8'h1C;
    localparam logic [7:0] OFS_AEQ_B    = 8'h1D;
    localparam logic [7:0] OFS_ADAPTIVE_EQ_LONG_CHANNEL = 8'h1E;
    localparam logic [7:0] OFS_CONN_EQ  = 8'h20;
    localparam logic [7:0] OFS_SUPERSPEED_TX_INPUT_EQUALIZER    = 8'h21;
    localparam logic [7:0] OFS_USB_MISC = 8'h22;
    localparam logic [7:0] OFS_USB_STAT = 8'h24;
    localparam logic [7:0] OFS_VOD      = 8'h32;
    localparam logic [7:0] OFS_AEQ_RES  = 8'h3B;

    // Plain read/write registers, index order of misc storage
    localparam int NUM_MISC = 8;
    localparam logic [NUM_MISC-1:0][7:0] MISC_OFS = {
        OFS_VOD, OFS_USB_MISC, OFS_SUPERSPEED_TX_INPUT_EQUALIZER, OFS_CONN_EQ,
        OFS_ADAPTIVE_EQ_LONG_CHANNEL, OFS_AEQ_B, OFS_AEQ_A, OFS_LANE_EN
    };

    // Field positions of the mode register
    localparam int BIT_LIMIT    = 7;
    localparam int BIT_HP_SWAP  = 5;
    localparam int BIT_EQ_SRC   = 4;
    localparam int BIT_HP_FORCE = 3;
    localparam int BIT_FLIP     = 2;
    localparam int MODE_LSB     = 0;

    localparam logic [7:0] RST_MODE     = 8'h01;
    localparam logic [7:0] RST_TXSHAPE  = 8'h6C;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] MASK_MODE    = 8'hBF;
    localparam logic [7:0] MASK_TXSHAPE = 8'hFC;
    localparam logic [3:0] LANES_NONE   = 4'h0;
    localparam logic [3:0] LANES_PAIR   = 4'h3;
    localparam logic [3:0] LANES_ALL    = 4'hF;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_USB,
        MODE_DISP4,
        MODE_USB_DISP2
    } cpx_mode_e;

    typedef struct packed {
        logic      receive_pair_limiting_select;
        logic      rsvd;
        logic      hotplug_pin_swap;
        logic      equalizer_source_select;
        logic      hotplug_force_high;
        logic      flip;
        cpx_mode_e operating_mode_select;
    } cpx_mode_reg_s;

    typedef struct packed {
        logic       rsvd;
        logic [1:0] power_state;
        logic [4:0] lane_count;
    } cpx_snoop_s;

    typedef struct packed {
        logic       usb_enable;
        logic [3:0] disp_lane_en;
        logic       flip;
        logic       receive_pair_limiting_select;
        logic       hotplug_input_signal;
    } cpx_path_s;

endpackage

/* logic/cpx_sync.sv */
// Purpose: Multi-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_sys_i
// Notes:   Only the last stage leaves the module
`timescale 1ns/1ps
module cpx_sync #(
    parameter int W      = 1,
    parameter int STAGES = 2
) (
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    if (STAGES < 2 || W < 1)
    begin : g_chk
        $error("cpx_sync needs STAGES >= 2 and W >= 1");
    end

    typedef struct packed {
        logic [STAGES-1:0][W-1:0] chain;
    } cpx_sync_s;

    cpx_sync_s st;
    cpx_sync_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.chain = {st.chain[STAGES-2:0], d_i};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign q_o = st.chain[STAGES-1];
endmodule

/* testbench/cpx_config_regs_props.sv */
// Purpose: Port checks for the config bank
// Assumes: One clock, sync active-low reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module cpx_props (
    input wire logic               clk_sys_i,
    input wire logic               nrst_i,
    input wire logic [7:0]         reg_addr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [7:0]         reg_rdata_o,
    input wire logic [7:0]         usb_state_i,
    input wire logic [7:0]         adaptive_equalization_result_i,
    input wire cpx_pkg::cpx_path_s path_o,
    input wire logic [7:0]         tx_shaping_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    logic       listed;
    logic [7:0] wd1;
    logic [7:0] wd2;
    function automatic logic [4:0] dec(input logic [1:0] m);
        return (m == 2'h0) ? 5'h00 : (m == 2'h1) ? 5'h10 :
               (m == 2'h2) ? 5'h0F : 5'h13;
    endfunction
    always_comb
    begin
        case (reg_addr_i)
            8'h0A, 8'h0B, 8'h10, 8'h11, 8'h12, 8'h13, 8'h1C, 8'h1D,
            8'h1E, 8'h20, 8'h21, 8'h22, 8'h24, 8'h32, 8'h3B: listed = 1'h1;
            default: listed = 1'h0;
        endcase
    end
    // Write data two edges back, matches path lag
    always_ff @(posedge clk_sys_i)
    begin
        wd1 <= reg_wdata_i;
        wd2 <= wd1;
    end
    sequence mode_wr;
        reg_wr_i && reg_addr_i == 8'h0A;
    endsequence
    sequence rd_at(logic [7:0] a);
        reg_rd_i && reg_addr_i == a && $past(nrst_i);
    endsequence
    usb_stat_a: assert property (rd_at(8'h24)
        ##0 $stable(usb_state_i) |=> reg_rdata_o == $past(usb_state_i))
        else $error("usb status");
    aeq_res_a: assert property (rd_at(8'h3B)
        ##0 $stable(adaptive_equalization_result_i) |=> reg_rdata_o ==
        $past(adaptive_equalization_result_i)) else $error("adaptive_eq_result");
    unlisted_rd_a: assert property (reg_rd_i && !listed
        |=> reg_rdata_o == 8'h00) else $error("unlisted read");
    mode_dec_a: assert property (mode_wr |-> ##2
        {path_o.usb_enable, path_o.disp_lane_en} == dec(wd2[1:0]))
        else $error("mode decode");
    flip_a: assert property (mode_wr
        |-> ##2 path_o.flip == wd2[2]) else $error("flip");
    limit_a: assert property (mode_wr |-> ##2
        path_o.receive_pair_limiting_select == wd2[7]) else $error("limit");
    hp_force_a: assert property (mode_wr ##0 reg_wdata_i[3]
        |-> ##2 path_o.hotplug_input_signal) else $error("hp force");
    rsvd_rd_a: assert property (rd_at(8'h0A)
        |=> !reg_rdata_o[6]) else $error("reserved bit");
    tx_rsvd_a: assert property (tx_shaping_o[1:0] == 2'h0)
        else $error("tx reserved");
endmodule
bind cpx_config_regs cpx_props u_props (.clk_sys_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .usb_state_i,
    .adaptive_equalization_result_i, .path_o, .tx_shaping_o);

/* testbench/cpx_config_regs_tb_top.sv */
// Purpose: Register-level tests of the config bank
// Assumes: Strobes driven 1 ns after the rising edge
// Notes:   Reads sample data the cycle after the strobe
`timescale 1ns/1ps
module cpx_config_regs_tb_top;
    logic               clk_sys_i, nrst_i, wr, rd, sreq, supd;
    logic [7:0]         addr, wdata, rdata, ust, adaptive_equalization, txs, nsn, v;
    logic [1:0]         hp, hpin;
    logic [3:0]         eq, eqp;
    logic [6:0]         sval, sfar;
    cpx_pkg::cpx_path_s path;
    logic [3:0][3:0]    lane_eq;
    logic [cpx_pkg::NUM_MISC-1:0][7:0] misc;
    logic [4:0]         dec [4] = '{5'h00, 5'h10, 5'h0F, 5'h13};
    logic [7:0]         bad [5] = '{8'h00, 8'h05, 8'h23, 8'h3F, 8'hFF};
    int                 mismatches, num_checks, cyc;
    cpx_config_regs dut (.clk_sys_i, .nrst_i, .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .hotplug_input_i(hpin),
        .display_equalizer_pins_i(eqp), .snoop_update_i(supd),
        .snoop_power_state_i(sfar[6:5]), .snoop_lane_count_i(sfar[4:0]),
        .usb_state_i(ust), .adaptive_equalization_result_i(adaptive_equalization),
        .path_o(path), .lane_eq_o(lane_eq), .tx_shaping_o(txs),
        .misc_o(misc));
    cpx_far_side far (.clk_sys_i, .hp_i(hp), .eq_i(eq), .snoop_req_i(sreq),
        .snoop_val_i(sval), .hotplug_o(hpin), .eq_pins_o(eqp),
        .snoop_update_o(supd), .snoop_o(sfar), .usb_state_o(ust),
        .aeq_result_o(adaptive_equalization));
    initial
    begin
        clk_sys_i = 1'h0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wrb(input logic [7:0] a, d);
        addr = a;
        wdata = d;
        wr = 1'h1;
        step(1);
        wr = 1'h0;
        step(1);
    endtask
    task automatic rdc(input logic [7:0] a, e);
        addr = a;
        rd = 1'h1;
        step(1);
        rd = 1'h0;
        chk($sformatf("reg %h", a), rdata, e);
        step(1);
    endtask
    task automatic snoop(input logic [6:0] s);
        sval = s;
        sreq = 1'h1;
        step(1);
        sreq = 1'h0;
        nsn++;
        step(3);
    endtask
    initial
    begin
        {nrst_i, wr, rd, sreq, addr, wdata, hp, eq, sval, nsn} = 41'h0;
        step(3);
        nrst_i = 1'h1;
        rdc(8'h0A, 8'h01);
        rdc(8'h0B, 8'h6C);
        rdc(8'h13, 8'h00);
        chk("usb_en", path.usb_enable, 1'h1);
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            v = {m[1], 1'h1, 3'h0, m[0], m[1:0]};
            wrb(8'h0A, v);
            chk("lanes", path[7:3], dec[m]);
            chk("flip", path.flip, m[0]);
            chk("limit", path.receive_pair_limiting_select, m[1]);
            rdc(8'h0A, v & 8'hBF);
        end
        $display("test modes done");
        hp = 2'h2;
        wrb(8'h0A, 8'h01);
        step(4);
        chk("hp", path.hotplug_input_signal, 1'h0);
        wrb(8'h0A, 8'h21);
        chk("hp", path.hotplug_input_signal, 1'h1);
        hp = 2'h0;
        step(4);
        chk("hp", path.hotplug_input_signal, 1'h0);
        wrb(8'h0A, 8'h09);
        chk("hp", path.hotplug_input_signal, 1'h1);
        $display("test hotplug done");
        eq = 4'h9;
        wrb(8'h0A, 8'h01);
        step(4);
        rdc(8'h10, 8'h99);
        chk("lane_eq", lane_eq, 16'h9999);
        wrb(8'h10, 8'h5A);
        rdc(8'h10, 8'h99);
        wrb(8'h0A, 8'h11);
        wrb(8'h10, 8'h5A);
        wrb(8'h11, 8'hC3);
        rdc(8'h10, 8'h5A);
        rdc(8'h11, 8'hC3);
        chk("lane_eq", lane_eq, 16'hC35A);
        $display("test eq done");
        wrb(8'h0A, 8'h03);
        snoop(7'h44);
        rdc(8'h12, 8'h44);
        wrb(8'h12, 8'hFF);
        rdc(8'h12, 8'h44);
        wrb(8'h0A, 8'h01);
        rdc(8'h12, 8'h00);
        $display("test snoop done");
        rdc(8'h24, nsn);
        rdc(8'h3B, ~nsn);
        snoop(7'h00);
        rdc(8'h24, nsn);
        rdc(8'h3B, ~nsn);
        $display("test status done");
        wrb(8'h13, 8'h5A);
        chk("misc0", misc[0], 8'h5A);
        foreach (bad[i])
        begin
            wrb(bad[i], 8'hFF);
            rdc(bad[i], 8'h00);
        end
        rdc(8'h0A, 8'h01);
        rdc(8'h13, 8'h5A);
        $display("test unlisted done");
        wrb(8'h0B, 8'hFF);
        rdc(8'h0B, 8'hFC);
        chk("txs", txs, 8'hFC);
        // Mid-run reset must restore defaults over written values
        nrst_i = 1'h0;
        step(3);
        nrst_i = 1'h1;
        rdc(8'h0A, 8'h01);
        rdc(8'h0B, 8'h6C);
        rdc(8'h13, 8'h00);
        chk("misc0", misc[0], 8'h00);
        $display("test rerun reset done");
        results();
    end
endmodule

/* testbench/cpx_far_side.sv */
// Purpose: Far side: pins, sideband snoop and link status
// Assumes: Outputs move on the clock edge
// Notes:   Link state steps once per snoop event
`timescale 1ns/1ps
module cpx_far_side (
    input  wire logic       clk_sys_i,
    input  wire logic [1:0] hp_i,
    input  wire logic [3:0] eq_i,
    input  wire logic       snoop_req_i,
    input  wire logic [6:0] snoop_val_i,
    output logic      [1:0] hotplug_o,
    output logic      [3:0] eq_pins_o,
    output logic            snoop_update_o,
    output logic      [6:0] snoop_o,
    output logic      [7:0] usb_state_o,
    output logic      [7:0] aeq_result_o
);
    initial
    begin
        {hotplug_o, eq_pins_o, snoop_update_o, snoop_o} = 14'h0000;
        usb_state_o = 8'h00;
    end
    // Status moves with no register write at all
    assign aeq_result_o = ~usb_state_o;
    always @(posedge clk_sys_i)
    begin
        hotplug_o <= hp_i;
        eq_pins_o <= eq_i;
        snoop_update_o <= snoop_req_i;
        snoop_o <= snoop_val_i;
        if (snoop_req_i)
            usb_state_o <= usb_state_o + 8'h01;
    end
endmodule
